// ==== hw/tsi_pkg.sv ====
// shared constants and types for the switch port ends
package tsi_pkg;
    localparam int NSTREAM = 8;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;
    localparam int BYTE_W = 8;
    localparam int CNT_W = 9;
    localparam int SYS_HZ = 250_000_000;
    localparam int SCLK_HZ = 4_096_000;
    localparam int STREAM_BPS = 2_048_000;
    localparam int SCLK_PER_BIT = SCLK_HZ / STREAM_BPS;
    localparam int SCLK_HALF_CYC = SYS_HZ / (2 * SCLK_HZ);
    localparam int RESET_MIN_NS = 100;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * (SYS_HZ / 1_000_000) + 999) / 1000;
    localparam int BUS_HOLD_CYC = 12;
    localparam int BUS_RECOVER_CYC = 6;
    localparam logic [CNT_W-1:0] CNT_LAST = 9'h1ff;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] IDLE_RUN = 4'h8;
    localparam logic [5:0] DIV_LAST = 6'(SCLK_HALF_CYC - 1);
    localparam logic [5:0] HOLD_LAST = 6'(BUS_HOLD_CYC - 1);
    localparam logic [5:0] RECOVER_LAST = 6'(BUS_RECOVER_CYC - 1);
    localparam logic [5:0] RESET_LAST = 6'(RESET_MIN_CYC - 1);
    localparam logic [5:0] CNT6_ZERO = 6'h00;
    localparam logic [DATA_W-1:0] BUS_PULL = 16'hffff;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

    // device processor port access states
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_READ = 3'b010,
        ACC_WRITE = 3'b100
    } tsi_acc_type;

    // host bus cycle states
    typedef enum logic [4:0] {
        HB_IDLE = 5'b00001,
        HB_ADDR = 5'b00010,
        HB_GAP = 5'b00100,
        HB_STROBE = 5'b01000,
        HB_RECOVER = 5'b10000
    } tsi_hbus_type;
endpackage

// ==== hw/tsi_link_if.sv ====
// pin-level link between the switch port and its host and stream peers
interface tsi_link_if;
    import tsi_pkg::*;
    logic serial_clk;
    logic frame_pulse_in;
    logic [NSTREAM-1:0] serial_in_streams;
    logic [NSTREAM-1:0] serial_out_streams;
    logic [NSTREAM-1:0] serial_out_oe_n;
    logic [NSTREAM-1:0] serial_out_line;
    logic cs_n;
    logic strobe_in;
    logic rw_wr;
    logic address_latch_strobe;
    logic port_mode_select;
    logic sep_strobe_style;
    logic [ADDR_W-1:0] nonmux_address_lines;
    logic [DATA_W-1:0] host_data;
    logic host_data_oe_n;
    logic [DATA_W-1:0] dev_data;
    logic dev_data_oe_n;
    logic [DATA_W-1:0] bus_data;

    // wire resolution, pulled high when nobody drives
    assign bus_data = !dev_data_oe_n ? dev_data : (!host_data_oe_n ? host_data : BUS_PULL);
    assign serial_out_line = (serial_out_streams | serial_out_oe_n);

    modport dev (
        input serial_clk, frame_pulse_in, serial_in_streams, cs_n, strobe_in, rw_wr,
        input address_latch_strobe, port_mode_select, sep_strobe_style,
        input nonmux_address_lines, bus_data,
        output serial_out_streams, serial_out_oe_n, dev_data, dev_data_oe_n
    );
    modport host (
        output serial_clk, frame_pulse_in, serial_in_streams, cs_n, strobe_in, rw_wr,
        output address_latch_strobe, port_mode_select, sep_strobe_style,
        output nonmux_address_lines, host_data, host_data_oe_n,
        input serial_out_line, bus_data
    );
endinterface

// ==== hw/tsi_dev_end.sv ====
// switch device end: serial streams, frame alignment and processor port
//
// Overview of operation
// - eight three-state serial outputs at 2.048 Mb/s
// - eight serial inputs carry 2.048 Mb/s data
// - 4.096 MHz serial clock shifts all streams
// - frame pulse polarity detected automatically
// - reset clears counters and registers
// - reset tristates serial outputs and data bus
// - reset held low at least 100 ns; host end meets it on reset_req_i only, not after resetn_i
// - non-multiplexed mode uses dedicated address lines
// - muxed direction style: strobe high enables access
// - non-muxed style: strobe low enables access
// - separate strobes: read low drives data bus
// - direction input selects read or write
// - separate strobes: write low captures data
// - mode select high means multiplexed port
// - strobes ignored while chip select negated
// - address latch strobe used only when multiplexed
// - frames of 32 eight-bit channels from pulse
module tsi_dev_end
    import tsi_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    tsi_link_if.dev link,
    output logic frame_start_o,
    output logic frame_high_o,
    output logic write_done_o
);

    localparam int PIN_W = NSTREAM + ADDR_W + DATA_W + 8;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic sclk_s, fp_s, cs_s, strobe_s, rw_s, ale_s, mode_s, sep_s;
    logic [NSTREAM-1:0] rx_s;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;
    logic sclk_d_q, sclk_rise, sclk_fall;
    logic fp_prev_q, idle_lvl_q, fp_act, fp_act_d_q, locked_q, fmt_ok_q;
    logic [3:0] run_q;
    logic [CNT_W-1:0] cnt_q;
    logic [4:0] chan, chan_next;
    logic sample_en, shift_en, byte_end;
    logic [BYTE_W-1:0] rx_sh_q [NSTREAM];
    logic [BYTE_W-1:0] tx_sh_q [NSTREAM];
    logic [BYTE_W-1:0] rx_mem_q [256];
    logic [BYTE_W-1:0] tx_mem_q [256];
    logic [NSTREAM-1:0] tx_q;
    logic [NSTREAM-1:0] tx_oe_n_q;
    logic rd_req, wr_req;
    logic [ADDR_W-1:0] addr_lat_q, acc_addr_q, cur_addr;
    logic [DATA_W-1:0] wdata_q, rdata_q;
    logic data_oe_n_q;
    tsi_acc_type acc_q;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, two flops on everything from outside; select is
    // inverted so the cleared flops read as deselected, not as a stray access
    assign pin_raw = {link.serial_clk, link.frame_pulse_in, link.serial_in_streams,
                      ~link.cs_n, link.strobe_in, link.rw_wr, link.address_latch_strobe,
                      link.port_mode_select, link.sep_strobe_style,
                      link.nonmux_address_lines, link.bus_data};
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end
    assign {sclk_s, fp_s, rx_s, cs_s, strobe_s, rw_s, ale_s, mode_s, sep_s,
            addr_s, data_s} = pin_s2_q;

    ////////////////////////////////////////////////////////////////////////////
    // serial clock edges
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sclk_d_q <= 1'b0;
        end else begin
            sclk_d_q <= sclk_s;
        end
    end
    assign sclk_rise = sclk_s & ~sclk_d_q;
    assign sclk_fall = ~sclk_s & sclk_d_q;

    // frame format detect: long-held level is idle; no frame lock before it is learned
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fp_prev_q <= 1'b1;
            run_q <= '0;
            idle_lvl_q <= 1'b1;
            fmt_ok_q <= 1'b0;
            frame_high_o <= 1'b0;
        end else if (sclk_fall) begin
            fp_prev_q <= fp_s;
            if (fp_s != fp_prev_q) begin
                run_q <= '0;
            end else if (run_q != IDLE_RUN) begin
                run_q <= run_q + 4'h1;
            end else begin
                idle_lvl_q <= fp_s;
                fmt_ok_q <= 1'b1;
                frame_high_o <= ~fp_s;
            end
        end
    end
    assign fp_act = (fp_s != idle_lvl_q);

    ////////////////////////////////////////////////////////////////////////////
    // frame position: half-bit, bit and channel counter
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            fp_act_d_q <= 1'b0;
            locked_q <= 1'b0;
            frame_start_o <= 1'b0;
        end else begin
            frame_start_o <= 1'b0;
            if (sclk_fall) begin
                fp_act_d_q <= fp_act;
            end
            if (sclk_fall && fp_act && !fp_act_d_q && fmt_ok_q) begin
                cnt_q <= CNT_LAST;
                locked_q <= 1'b1;
                frame_start_o <= 1'b1;
            end else if (sclk_rise) begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
    end
    assign chan = cnt_q[CNT_W-1:4];
    assign chan_next = chan + 5'h01;
    assign sample_en = sclk_rise & ~cnt_q[0];
    assign shift_en = sclk_rise & cnt_q[0];
    assign byte_end = (cnt_q[3:1] == BIT_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // per-stream receive and transmit shifters
    genvar gs;
    generate
        for (gs = 0; gs < NSTREAM; gs++) begin : g_stream
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    rx_sh_q[gs] <= '0;
                    tx_sh_q[gs] <= '0;
                    tx_q[gs] <= 1'b1;
                    tx_oe_n_q[gs] <= 1'b1;
                end else begin
                    if (sample_en) begin
                        rx_sh_q[gs] <= {rx_sh_q[gs][BYTE_W-2:0], rx_s[gs]};
                    end
                    if (shift_en && byte_end) begin
                        tx_sh_q[gs] <= {tx_mem_q[{3'(gs), chan_next}][BYTE_W-2:0], 1'b0};
                        tx_q[gs] <= tx_mem_q[{3'(gs), chan_next}][BYTE_W-1];
                    end else if (shift_en) begin
                        tx_sh_q[gs] <= {tx_sh_q[gs][BYTE_W-2:0], 1'b0};
                        tx_q[gs] <= tx_sh_q[gs][BYTE_W-1];
                    end
                    tx_oe_n_q[gs] <= ~locked_q;
                end
            end
        end
    endgenerate
    assign link.serial_out_streams = tx_q;
    assign link.serial_out_oe_n = tx_oe_n_q;

    // received byte store, one location per stream and channel
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 256; i++) begin
                rx_mem_q[i] <= BYTE_ZERO;
            end
        end else if (sample_en && byte_end) begin
            for (int s = 0; s < NSTREAM; s++) begin
                rx_mem_q[{3'(s), chan}] <= {rx_sh_q[s][BYTE_W-2:0], rx_s[s]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor port request decode
    always_comb begin
        rd_req = 1'b0;
        wr_req = 1'b0;
        if (!cs_s) begin
            rd_req = 1'b0;
        end else if (!mode_s) begin
            rd_req = ~strobe_s & rw_s;
            wr_req = ~strobe_s & ~rw_s;
        end else if (!sep_s) begin
            rd_req = strobe_s & rw_s;
            wr_req = strobe_s & ~rw_s;
        end else begin
            rd_req = ~strobe_s;
            wr_req = ~rw_s;
        end
    end

    // multiplexed address latch on the low data lines
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_lat_q <= '0;
        end else if (mode_s && ale_s) begin
            addr_lat_q <= data_s[ADDR_W-1:0];
        end
    end
    assign cur_addr = mode_s ? addr_lat_q : addr_s;

    // access state machine
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_q <= ACC_IDLE;
            acc_addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            data_oe_n_q <= 1'b1;
            write_done_o <= 1'b0;
        end else begin
            write_done_o <= 1'b0;
            case (acc_q)
                ACC_IDLE: begin
                    acc_addr_q <= cur_addr;
                    if (rd_req) begin
                        acc_q <= ACC_READ;
                    end else if (wr_req) begin
                        acc_q <= ACC_WRITE;
                    end
                end
                ACC_READ: begin
                    rdata_q <= {tx_mem_q[acc_addr_q], rx_mem_q[acc_addr_q]};
                    data_oe_n_q <= ~rd_req;
                    if (!rd_req) begin
                        acc_q <= ACC_IDLE;
                    end
                end
                ACC_WRITE: begin
                    if (wr_req) begin
                        wdata_q <= data_s;
                    end else begin
                        write_done_o <= 1'b1;
                        acc_q <= ACC_IDLE;
                    end
                end
                default: begin
                    acc_q <= ACC_IDLE;
                end
            endcase
        end
    end
    assign link.dev_data = rdata_q;
    assign link.dev_data_oe_n = data_oe_n_q;

    // transmit byte store, written by the processor port
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 256; i++) begin
                tx_mem_q[i] <= BYTE_ZERO;
            end
        end else if (acc_q == ACC_WRITE && !wr_req) begin
            tx_mem_q[acc_addr_q] <= wdata_q[BYTE_W-1:0];
        end
    end

endmodule

// ==== hw/tsi_host_end.sv ====
// host end: serial clock, frame pulse, stream peers and processor bus master
module tsi_host_end
    import tsi_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    tsi_link_if.host link,
    input wire logic mode_mux_i,
    input wire logic sep_strobe_i,
    input wire logic frame_high_i,
    input wire logic [NSTREAM*BYTE_W-1:0] stream_bytes_i,
    input wire logic reset_req_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [ADDR_W-1:0] cmd_addr_i,
    input wire logic [DATA_W-1:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [DATA_W-1:0] rsp_rdata_o,
    output logic [NSTREAM*BYTE_W-1:0] tx_bytes_o,
    output logic [4:0] tx_chan_o,
    output logic tx_valid_o,
    output logic dev_resetn_o
);

    logic [5:0] div_q, wait_q, rst_cnt_q;
    logic sclk_q, rise;
    logic [CNT_W-1:0] cnt_q, cnt_n;
    logic fp_q;
    logic [NSTREAM-1:0] rx_q, tx_s1_q, tx_s2_q;
    logic [BYTE_W-1:0] tx_sh_q [NSTREAM];
    logic [DATA_W-1:0] rd_s1_q, rd_s2_q;
    tsi_hbus_type st_q;
    logic wr_q, mux_q, sep_q;
    logic cs_n_q, strobe_q, rw_q, ale_q, oe_n_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q, bus_q;
    logic strobe_idle;

    ////////////////////////////////////////////////////////////////////////////
    // device reset pulse of at least the minimum width on reset_req_i; released on the first clock after resetn_i rises
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_cnt_q <= '0;
            dev_resetn_o <= 1'b0;
        end else if (reset_req_i) begin
            rst_cnt_q <= RESET_LAST;
            dev_resetn_o <= 1'b0;
        end else if (rst_cnt_q != CNT6_ZERO) begin
            rst_cnt_q <= rst_cnt_q - 6'h01;
        end else begin
            dev_resetn_o <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial clock divider and frame counter
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= '0;
            sclk_q <= 1'b0;
        end else if (div_q == DIV_LAST) begin
            div_q <= '0;
            sclk_q <= ~sclk_q;
        end else begin
            div_q <= div_q + 6'h01;
        end
    end
    assign rise = (div_q == DIV_LAST) & ~sclk_q;
    assign cnt_n = cnt_q + 9'h001;

    // frame pulse spans the last clock of the frame, polarity per format
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= '0;
            fp_q <= 1'b1;
        end else begin
            if (rise) begin
                cnt_q <= cnt_n;
            end
            fp_q <= (cnt_q == CNT_LAST) ^ ~frame_high_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stream peers: drive input streams, sample output streams mid-bit
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_s1_q <= '1;
            tx_s2_q <= '1;
        end else begin
            tx_s1_q <= link.serial_out_line;
            tx_s2_q <= tx_s1_q;
        end
    end
    genvar gs;
    generate
        for (gs = 0; gs < NSTREAM; gs++) begin : g_peer
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    rx_q[gs] <= 1'b1;
                    tx_sh_q[gs] <= '0;
                    tx_bytes_o[gs*BYTE_W +: BYTE_W] <= '0;
                end else if (rise && !cnt_n[0]) begin
                    rx_q[gs] <= stream_bytes_i[gs*BYTE_W + 7 - 32'(cnt_n[3:1])];
                end else if (rise) begin
                    tx_sh_q[gs] <= {tx_sh_q[gs][BYTE_W-2:0], tx_s2_q[gs]};
                    if (cnt_n[3:1] == BIT_LAST) begin
                        tx_bytes_o[gs*BYTE_W +: BYTE_W] <= {tx_sh_q[gs][BYTE_W-2:0],
                                                           tx_s2_q[gs]};
                    end
                end
            end
        end
    endgenerate

    // received byte strobe with its channel
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_valid_o <= 1'b0;
            tx_chan_o <= '0;
        end else begin
            tx_valid_o <= rise & cnt_n[0] & (cnt_n[3:1] == BIT_LAST);
            if (rise && cnt_n[0] && cnt_n[3:1] == BIT_LAST) begin
                tx_chan_o <= cnt_n[CNT_W-1:4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor bus master
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_s1_q <= '0;
            rd_s2_q <= '0;
        end else begin
            rd_s1_q <= link.bus_data;
            rd_s2_q <= rd_s1_q;
        end
    end
    assign strobe_idle = ~(mux_q & ~sep_q); // idle level of the strobe pin

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_q <= HB_IDLE;
            wait_q <= '0;
            wr_q <= 1'b0;
            mux_q <= 1'b0;
            sep_q <= 1'b0;
            cs_n_q <= 1'b1;
            strobe_q <= 1'b1;
            rw_q <= 1'b1;
            ale_q <= 1'b0;
            oe_n_q <= 1'b1;
            addr_q <= '0;
            wdata_q <= '0;
            bus_q <= '0;
            cmd_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
        end else begin
            rsp_valid_o <= 1'b0;
            cmd_ready_o <= 1'b0;
            if (wait_q != CNT6_ZERO) begin
                wait_q <= wait_q - 6'h01;
            end
            case (st_q)
                HB_IDLE: begin
                    mux_q <= mode_mux_i;
                    sep_q <= sep_strobe_i;
                    strobe_q <= ~(mode_mux_i & ~sep_strobe_i);
                    cmd_ready_o <= 1'b1;
                    if (cmd_valid_i && cmd_ready_o) begin
                        cmd_ready_o <= 1'b0;
                        wr_q <= cmd_write_i;
                        addr_q <= cmd_addr_i;
                        wdata_q <= cmd_wdata_i;
                        bus_q <= {{(DATA_W-ADDR_W){1'b0}}, cmd_addr_i};
                        oe_n_q <= ~mux_q;
                        ale_q <= mux_q;
                        wait_q <= HOLD_LAST;
                        st_q <= mux_q ? HB_ADDR : HB_GAP;
                    end
                end
                HB_ADDR: begin
                    if (wait_q == CNT6_ZERO) begin
                        ale_q <= 1'b0;
                        wait_q <= HOLD_LAST;
                        st_q <= HB_GAP;
                    end
                end
                HB_GAP: begin
                    if (wait_q == CNT6_ZERO) begin
                        cs_n_q <= 1'b0;
                        bus_q <= wdata_q;
                        oe_n_q <= ~wr_q;
                        if (sep_q && mux_q) begin
                            strobe_q <= wr_q;
                            rw_q <= ~wr_q;
                        end else begin
                            strobe_q <= ~strobe_idle;
                            rw_q <= ~wr_q;
                        end
                        wait_q <= HOLD_LAST;
                        st_q <= HB_STROBE;
                    end
                end
                HB_STROBE: begin
                    if (wait_q == CNT6_ZERO) begin
                        rsp_rdata_o <= rd_s2_q;
                        strobe_q <= strobe_idle;
                        rw_q <= 1'b1;
                        wait_q <= RECOVER_LAST;
                        st_q <= HB_RECOVER;
                    end
                end
                HB_RECOVER: begin
                    if (wait_q == CNT6_ZERO) begin
                        cs_n_q <= 1'b1;
                        oe_n_q <= 1'b1;
                        rsp_valid_o <= 1'b1;
                        st_q <= HB_IDLE;
                    end
                end
                default: begin
                    st_q <= HB_IDLE;
                end
            endcase
        end
    end

    assign link.serial_clk = sclk_q;
    assign link.frame_pulse_in = fp_q;
    assign link.serial_in_streams = rx_q;
    assign link.cs_n = cs_n_q;
    assign link.strobe_in = strobe_q;
    assign link.rw_wr = rw_q;
    assign link.address_latch_strobe = ale_q;
    assign link.port_mode_select = mux_q;
    assign link.sep_strobe_style = sep_q;
    assign link.nonmux_address_lines = addr_q;
    assign link.host_data = bus_q;
    assign link.host_data_oe_n = oe_n_q;

endmodule

// ==== tb/tsi_link_assertions.sv ====
// link checker for the switch port ends
module tsi_link_assertions
    import tsi_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [NSTREAM-1:0] serial_out_streams,
    input wire logic [NSTREAM-1:0] serial_out_oe_n,
    input wire logic cs_n,
    input wire logic rw_wr,
    input wire logic address_latch_strobe,
    input wire logic port_mode_select,
    input wire logic sep_strobe_style,
    input wire logic host_data_oe_n,
    input wire logic dev_data_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] gap_q;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // cycles since the tx bits last moved, saturating
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i)
            gap_q <= 16'h0000;
        else
            gap_q <= $changed(serial_out_streams) ? 16'h0000 : gap_q + 16'(!(&gap_q));
    end
    sequence s_dev_release;
        !dev_data_oe_n ##1 dev_data_oe_n;
    endsequence
    AST_RST_TRISTATE: assert property ($rose(resetn_i) |-> &serial_out_oe_n && dev_data_oe_n)
        else $error("outputs driven at reset");
    AST_CS_QUIET: assert property (cs_n [*4] |-> dev_data_oe_n)
        else $error("bus driven without select");
    AST_NO_CONTEND: assert property (!dev_data_oe_n |-> host_data_oe_n)
        else $error("both ends drive the bus");
    AST_DRIVE_IN_CS: assert property (!dev_data_oe_n |-> !cs_n)
        else $error("read data outside select");
    AST_RELEASE: assert property (s_dev_release |-> ##[0:12] cs_n)
        else $error("access not closed");
    AST_ALE_MUX: assert property (!port_mode_select |-> !address_latch_strobe)
        else $error("latch strobe in plain mode");
    AST_WR_DATA: assert property (port_mode_select && sep_strobe_style && !rw_wr |-> !host_data_oe_n)
        else $error("write strobe without data");
    AST_TX_BIT: assert property ($changed(serial_out_streams) && !(|serial_out_oe_n)
        && $past(!(|serial_out_oe_n)) |-> gap_q >= 16'h0077) else $error("tx bit too short");
endmodule

// ==== tb/tsi_switch_port_interfaces_test.sv ====
// self-checking bench joining the device and host ends
module tsi_switch_port_interfaces_test;
    timeunit 1ns;
    timeprecision 100ps;
    import tsi_pkg::*;
    localparam logic [63:0] BYTES = 64'hf1e2d3c4b5a69788;
    logic clk_sys_i = 1'b0, resetn_i = 1'b0, mode_mux_i = 1'b0, sep_strobe_i = 1'b0;
    logic frame_high_i = 1'b1, reset_req_i = 1'b0, cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
    logic [7:0] cmd_addr_i = 8'h00;
    logic [15:0] cmd_wdata_i = 16'h0000, rsp_rdata_o;
    logic [63:0] tx_bytes_o;
    logic [4:0] tx_chan_o;
    logic cmd_ready_o, rsp_valid_o, tx_valid_o, dev_resetn, frame_start_o, frame_high_o;
    logic write_done_o;
    int num_errors = 0, cmp_count = 0, num_wr = 0;
    tsi_link_if tsi_link_if_i ();
    tsi_host_end tsi_host_end_i (.clk_sys_i, .resetn_i, .link(tsi_link_if_i), .mode_mux_i,
        .sep_strobe_i, .frame_high_i, .stream_bytes_i(BYTES), .reset_req_i, .cmd_valid_i,
        .cmd_write_i, .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .rsp_valid_o, .rsp_rdata_o,
        .tx_bytes_o, .tx_chan_o, .tx_valid_o, .dev_resetn_o(dev_resetn));
    tsi_dev_end tsi_dev_end_i (.clk_sys_i, .resetn_i(dev_resetn), .link(tsi_link_if_i),
        .frame_start_o, .frame_high_o, .write_done_o);
    tsi_link_assertions tsi_link_assertions_i (.clk_sys_i, .resetn_i(dev_resetn),
        .serial_out_streams(tsi_link_if_i.serial_out_streams),
        .serial_out_oe_n(tsi_link_if_i.serial_out_oe_n), .cs_n(tsi_link_if_i.cs_n),
        .rw_wr(tsi_link_if_i.rw_wr), .address_latch_strobe(tsi_link_if_i.address_latch_strobe),
        .port_mode_select(tsi_link_if_i.port_mode_select),
        .sep_strobe_style(tsi_link_if_i.sep_strobe_style),
        .host_data_oe_n(tsi_link_if_i.host_data_oe_n),
        .dev_data_oe_n(tsi_link_if_i.dev_data_oe_n));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // one host command, waiting for ready and for the answer
    task automatic cmd(input logic wr, input logic [7:0] a, input logic [15:0] d);
        int n;
        for (n = 0; n < 100 && cmd_ready_o !== 1'b1; n++)
            step(1);
        if (cmd_ready_o !== 1'b1)
            num_errors++;
        cmd_valid_i = 1'b1;
        cmd_write_i = wr;
        cmd_addr_i = a;
        cmd_wdata_i = d;
        step(1);
        cmd_valid_i = 1'b0;
        for (n = 0; n < 100 && rsp_valid_o !== 1'b1; n++)
            step(1);
        if (rsp_valid_o !== 1'b1)
            num_errors++;
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // free running system clock
    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    // hang guard
    initial begin
        #400000;
        num_errors++;
        summarize();
    end
    // count writes the device reports as stored
    always @(posedge clk_sys_i) begin
        if (write_done_o === 1'b1)
            num_wr++;
    end
    // main sequence
    initial begin
        int n;
        step(5);
        resetn_i = 1'b1;
        for (n = 0; n < 40000 && frame_start_o !== 1'b1; n++)
            step(1);
        if (frame_start_o !== 1'b1)
            num_errors++;
        step(3000);
        chk(16'(frame_high_o), 16'h0001);
        for (int m = 0; m < 3; m++) begin
            mode_mux_i = (m != 0);
            sep_strobe_i = (m == 2);
            cmd(1'b1, {3'(m + 1), 5'h01}, 16'h005a + 16'(m));
            cmd(1'b0, {3'(m + 1), 5'h01}, 16'h0000);
            chk(rsp_rdata_o, {8'h5a + 8'(m), BYTES[8 * (m + 1) +: 8]});
        end
        chk(16'(num_wr), 16'h0003);
        for (n = 0; n < 40000 && !(tx_valid_o === 1'b1 && tx_bytes_o[31:24] === 8'h5c); n++)
            step(1);
        if (tx_valid_o !== 1'b1)
            num_errors++;
        chk({tx_bytes_o[23:16], tx_bytes_o[15:8]}, 16'h5b5a);
        chk(16'(tx_chan_o), 16'h0001);
        reset_req_i = 1'b1;
        step(1);
        reset_req_i = 1'b0;
        step(2);
        chk(16'({tsi_link_if_i.dev_data_oe_n, tsi_link_if_i.serial_out_oe_n}), 16'h01ff);
        step(40);
        cmd(1'b0, 8'h41, 16'h0000);
        chk(rsp_rdata_o, 16'h0000);
        summarize();
    end
endmodule
